// file: src/fpd_pkg.sv
// Shared constants and types for the floppy controller power-down and reset sequencer
package fpd_pkg;
   // Register byte offsets
   localparam logic [7:0] ADR_DSR = 8'h00;
   localparam logic [7:0] ADR_DOUT = 8'h04;
   localparam logic [7:0] ADR_CFGCTL = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h0c;
   localparam logic [7:0] ADR_DATA = 8'h10;
   localparam logic [7:0] ADR_MODE = 8'h14;
   localparam logic [7:0] ADR_CFG = 8'h18;
   localparam logic [7:0] ADR_PWR = 8'h1c;
   // Rate select fields
   localparam int DSR_RST_BIT = 7;
   localparam int DSR_LP_BIT = 6;
   // Digital output fields
   localparam int DOUT_RSTN_BIT = 2;
   // Main status fields
   localparam int STAT_READY_BIT = 7;
   // Mode word fields
   localparam int MODE_MLP_BIT = 0;
   localparam int MODE_ALP_BIT = 1;
   localparam int MODE_FIFO_WR_BIT = 2;
   localparam int MODE_FIFO_RD_BIT = 3;
   localparam int MODE_BURST_BIT = 4;
   // Configure word fields
   localparam int CFG_FIFO_BIT = 0;
   localparam int CFG_THR_LSB = 1;
   localparam int CFG_THR_MSB = 4;
   localparam int CFG_PRE_LSB = 8;
   localparam int CFG_PRE_MSB = 15;
   localparam int CFG_ISEEK_BIT = 16;
   localparam int CFG_POLL_BIT = 17;
   localparam int CFG_LOCK_BIT = 31;
   // Power control fields
   localparam int PWR_OSCSEL_BIT = 0;
   // Reset values
   localparam logic [7:0] DSR_RST = 8'h00;
   localparam logic [7:0] DOUT_RST = 8'h04;
   localparam logic [7:0] CFGCTL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [31:0] CFG_RST = 32'h0002_0000;
   localparam logic [7:0] PWR_RST = 8'h00;
   localparam logic [7:0] STAT_BUSY = 8'h00;
   localparam logic [7:0] STAT_READY = 8'h80;
   // Timing in printed units
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned T_IDLE_MS = 500;
   localparam int unsigned T_RDY_NS = 2500;
   localparam int unsigned T_OSC_US = 2000;
   // Cycle counts, longest times rounded down
   localparam int unsigned CYC_IDLE = T_IDLE_MS * CLK_MHZ * 1000;
   localparam int unsigned CYC_RDY = T_RDY_NS * CLK_MHZ / 1000;
   localparam int unsigned CYC_OSC = T_OSC_US * CLK_MHZ;
   // Sequencer states
   typedef enum logic [3:0]
   {
      ST_INIT = 4'b0001,
      ST_RUN = 4'b0010,
      ST_DOWN = 4'b0100,
      ST_WAKE = 4'b1000
   } fpd_state_t;
endpackage

// file: src/fpd_if.sv
// Interfaces between the sequencer and its timer and parameter store
`timescale 1ns/10ps
interface fpd_tmr_if;
   logic run; // Count while high
   logic done; // Level once the count expired
   modport tmr (input run, output done);
   modport ctl (output run, input done);
endinterface

interface fpd_par_if;
   logic soft_rst; // Software reset level
   logic cfg_we; // Configure word write
   logic mode_we; // Mode word write
   logic [31:0] wdata; // Write data
   logic [31:0] cfg; // Stored configure word
   logic [7:0] mode; // Stored mode word
   modport store (input soft_rst, cfg_we, mode_we, wdata, output cfg, mode);
   modport ctl (output soft_rst, cfg_we, mode_we, wdata, input cfg, mode);
endinterface

// file: src/fpd_timer.sv
// Parameterised delay counter
`timescale 1ns/10ps
module fpd_timer
#(
   parameter int unsigned COUNT = 16
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   fpd_tmr_if.tmr t
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_r; // Cycles spent running

   // Count while run holds; dropping run restarts from zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
         t.done <= 1'b0;
      end
      else if (!t.run)
      begin
         cnt_r <= '0;
         t.done <= 1'b0;
      end
      else if (!t.done)
      begin
         cnt_r <= cnt_r + 1'b1;
         t.done <= (cnt_r == W'(COUNT - 1));
      end
   end
endmodule

// file: src/fpd_param_store.sv
// Configure and mode parameters with lock retention over software reset
`timescale 1ns/10ps
module fpd_param_store
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Parameter access
   fpd_par_if.store p
);
   logic lock; // Retention enabled
   logic [31:0] cfg_keep; // Configure word as after a soft reset
   logic [7:0] mode_keep; // Mode word as after a soft reset

   // Locked fields survive, the rest go back to defaults
   always_comb
   begin
      lock = p.cfg[fpd_pkg::CFG_LOCK_BIT];
      cfg_keep = fpd_pkg::CFG_RST;
      mode_keep = fpd_pkg::MODE_RST;
      cfg_keep[fpd_pkg::CFG_LOCK_BIT] = lock;
      if (lock)
      begin
         cfg_keep[fpd_pkg::CFG_FIFO_BIT] = p.cfg[fpd_pkg::CFG_FIFO_BIT];
         cfg_keep[fpd_pkg::CFG_THR_MSB:fpd_pkg::CFG_THR_LSB] =
            p.cfg[fpd_pkg::CFG_THR_MSB:fpd_pkg::CFG_THR_LSB];
         cfg_keep[fpd_pkg::CFG_PRE_MSB:fpd_pkg::CFG_PRE_LSB] =
            p.cfg[fpd_pkg::CFG_PRE_MSB:fpd_pkg::CFG_PRE_LSB];
         mode_keep[fpd_pkg::MODE_FIFO_WR_BIT] = p.mode[fpd_pkg::MODE_FIFO_WR_BIT];
         mode_keep[fpd_pkg::MODE_FIFO_RD_BIT] = p.mode[fpd_pkg::MODE_FIFO_RD_BIT];
         mode_keep[fpd_pkg::MODE_BURST_BIT] = p.mode[fpd_pkg::MODE_BURST_BIT];
      end
   end

   // Configure word: master reset defaults, soft reset wins over a write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         p.cfg <= fpd_pkg::CFG_RST;
      else if (p.soft_rst)
         p.cfg <= cfg_keep;
      else if (p.cfg_we)
         p.cfg <= p.wdata;
   end

   // Mode word, auto low power stays until reset or rewrite
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         p.mode <= fpd_pkg::MODE_RST;
      else if (p.soft_rst)
         p.mode <= mode_keep;
      else if (p.mode_we)
         p.mode <= p.wdata[7:0];
   end
endmodule

// file: src/fpd_power_seq.sv
// Power-down and reset sequencer top with APB register slave
`timescale 1ns/10ps
module fpd_power_seq
#(
   parameter int unsigned IDLE_CYC = fpd_pkg::CYC_IDLE,
   parameter int unsigned OSC_CYC = fpd_pkg::CYC_OSC
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controller engine status
   input wire logic eng_idle,
   input wire logic eng_ready,
   // Power and reset controls
   output logic fdc_clk_en,
   output logic osc_en,
   output logic ctl_reset,
   // Drive and rate outputs
   output logic [7:0] drive_ctl_out,
   output logic [1:0] data_rate,
   output logic [2:0] precomp_sel,
   // Controller parameters
   output logic fifo_en,
   output logic [3:0] fifo_threshold_param,
   output logic [7:0] precomp_start_track,
   output logic implied_seek_en,
   output logic poll_en,
   output logic mode_fifo_write_param,
   output logic mode_fifo_read_param,
   output logic mode_burst_param
);

   fpd_pkg::fpd_state_t st_r; // Sequencer state
   fpd_pkg::fpd_state_t st_nxt; // Next state
   logic [7:0] dsr_r; // Data rate select register
   logic [7:0] digital_output_reg; // Digital output register
   logic [7:0] config_control_reg; // Configuration control register
   logic [7:0] pwr_r; // Power control register
   logic [7:0] data_r; // Data register
   logic [1:0] rate_r; // Rate from last rate write
   logic request_for_master; // Status ready bit
   logic mlp_pend_r; // Mode manual low power pending
   logic rst_pend_r; // Software reset seen while down
   logic osc_off_r; // Oscillator stopped for this power-down
   logic clk_en_r; // Controller clock running
   logic osc_en_r; // Oscillator running
   logic [31:0] prdata_r; // Read data
   logic pready_r; // Access phase ready
   logic pslverr_r; // Unmapped address
   logic setup; // Setup cycle
   logic acc; // Completing access
   logic wr; // Completing write
   logic mapped; // Address decodes
   logic [7:0] adr; // Low address byte
   logic dsr_wr; // Rate select write
   logic sw_rst; // Software reset request
   logic hold; // Output register holds reset
   logic wake_acc; // Status or data access
   logic lp_req; // Manual low power request

   fpd_tmr_if rdy_t ();
   fpd_tmr_if idle_t ();
   fpd_tmr_if osc_t ();
   fpd_par_if par ();

   // Bus decode
   assign adr = paddr[7:0];
   assign setup = psel & ~penable;
   assign acc = psel & penable & pready_r;
   assign wr = acc & pwrite & ~pslverr_r;
   assign mapped = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'b00) && (adr <= fpd_pkg::ADR_PWR);
   assign dsr_wr = wr && (adr == fpd_pkg::ADR_DSR);
   // Output reset bit is a level and never self-clears
   assign hold = ~digital_output_reg[fpd_pkg::DOUT_RSTN_BIT];
   assign sw_rst = (dsr_wr && pwdata[fpd_pkg::DSR_RST_BIT]) || hold;
   assign wake_acc = acc && ((adr == fpd_pkg::ADR_STAT) || (adr == fpd_pkg::ADR_DATA));
   assign lp_req = dsr_r[fpd_pkg::DSR_LP_BIT] | mlp_pend_r | (dsr_wr & pwdata[fpd_pkg::DSR_LP_BIT])
      | (par.mode_we & pwdata[fpd_pkg::MODE_MLP_BIT]);

   // Timers
   assign rdy_t.run = (st_r == fpd_pkg::ST_INIT) && !hold;
   assign idle_t.run = (st_r == fpd_pkg::ST_RUN) && par.mode[fpd_pkg::MODE_ALP_BIT] && eng_idle;
   assign osc_t.run = (st_r == fpd_pkg::ST_WAKE) && osc_off_r;
   fpd_timer #(.COUNT(fpd_pkg::CYC_RDY)) u_rdy (.pclk(pclk), .presetn(presetn), .t(rdy_t.tmr));
   fpd_timer #(.COUNT(IDLE_CYC)) u_idle (.pclk(pclk), .presetn(presetn), .t(idle_t.tmr));
   fpd_timer #(.COUNT(OSC_CYC)) u_osc (.pclk(pclk), .presetn(presetn), .t(osc_t.tmr));

   // Parameter store hookup
   assign par.soft_rst = sw_rst;
   assign par.cfg_we = wr && (adr == fpd_pkg::ADR_CFG);
   assign par.mode_we = wr && (adr == fpd_pkg::ADR_MODE);
   assign par.wdata = pwdata;
   fpd_param_store u_par (.pclk(pclk), .presetn(presetn), .p(par.store));

   // Next state
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         fpd_pkg::ST_INIT:
            if (!hold && rdy_t.done)
               st_nxt = fpd_pkg::ST_RUN;
         fpd_pkg::ST_RUN:
            if (sw_rst)
               st_nxt = fpd_pkg::ST_INIT;
            else if (lp_req || idle_t.done)
               st_nxt = fpd_pkg::ST_DOWN;
         fpd_pkg::ST_DOWN:
            if (sw_rst || wake_acc)
               st_nxt = fpd_pkg::ST_WAKE;
         fpd_pkg::ST_WAKE:
            // Stay until the oscillator has settled
            if (!osc_off_r || osc_t.done)
               st_nxt = (rst_pend_r || sw_rst) ? fpd_pkg::ST_INIT : fpd_pkg::ST_RUN;
         default:
            st_nxt = fpd_pkg::ST_INIT;
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= fpd_pkg::ST_INIT;
      else
         st_r <= st_nxt;
   end

   // Software reset during power-down is remembered through the wake-up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rst_pend_r <= 1'b0;
      else if (st_r == fpd_pkg::ST_DOWN || st_r == fpd_pkg::ST_WAKE)
         rst_pend_r <= rst_pend_r | sw_rst;
      else
         rst_pend_r <= 1'b0;
   end

   // Oscillator select is caught on entry so a later write cannot strand it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         osc_off_r <= 1'b0;
      else if (st_r == fpd_pkg::ST_RUN && st_nxt == fpd_pkg::ST_DOWN)
         osc_off_r <= pwr_r[fpd_pkg::PWR_OSCSEL_BIT];
   end

   // Clock and oscillator gating
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_en_r <= 1'b1;
         osc_en_r <= 1'b1;
      end
      else
      begin
         // Clock off while down and while the oscillator settles
         clk_en_r <= (st_nxt == fpd_pkg::ST_RUN) || (st_nxt == fpd_pkg::ST_INIT);
         if (st_r == fpd_pkg::ST_RUN && st_nxt == fpd_pkg::ST_DOWN)
            osc_en_r <= ~pwr_r[fpd_pkg::PWR_OSCSEL_BIT];
         else if (st_nxt != fpd_pkg::ST_DOWN)
            osc_en_r <= 1'b1;
      end
   end

   // Request for master only in the running state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         request_for_master <= 1'b0;
      else
         request_for_master <= (st_nxt == fpd_pkg::ST_RUN) && eng_ready;
   end

   // Rate select: reset bit self-clears, low power bit clears on wake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dsr_r <= fpd_pkg::DSR_RST;
      else
      begin
         if (dsr_wr)
            dsr_r <= {1'b0, pwdata[6:0]};
         if (st_r == fpd_pkg::ST_WAKE && st_nxt != fpd_pkg::ST_WAKE)
            dsr_r[fpd_pkg::DSR_LP_BIT] <= 1'b0;
      end
   end

   // Mode manual low power acts once per write, cleared on wake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mlp_pend_r <= 1'b0;
      else if (st_r == fpd_pkg::ST_WAKE && st_nxt != fpd_pkg::ST_WAKE)
         mlp_pend_r <= 1'b0;
      else if (par.mode_we && pwdata[fpd_pkg::MODE_MLP_BIT])
         mlp_pend_r <= 1'b1;
      else if (sw_rst)
         mlp_pend_r <= 1'b0;
   end

   // Output, config control, power and data registers, writable in any state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         digital_output_reg <= fpd_pkg::DOUT_RST;
         config_control_reg <= fpd_pkg::CFGCTL_RST;
         pwr_r <= fpd_pkg::PWR_RST;
         data_r <= 8'h00;
      end
      else if (wr)
      begin
         if (adr == fpd_pkg::ADR_DOUT)
            digital_output_reg <= pwdata[7:0];
         if (adr == fpd_pkg::ADR_CFGCTL)
            config_control_reg <= pwdata[7:0];
         if (adr == fpd_pkg::ADR_PWR)
            pwr_r <= pwdata[7:0];
         if (adr == fpd_pkg::ADR_DATA)
            data_r <= pwdata[7:0];
      end
   end

   // Data rate follows whichever of the two rate registers was written last
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rate_r <= 2'b00;
      else if (wr && (adr == fpd_pkg::ADR_DSR || adr == fpd_pkg::ADR_CFGCTL))
         rate_r <= pwdata[1:0];
   end

   // APB answer: zero wait states, data and error set up in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end
      else
      begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup && !pwrite)
         begin
            case (adr)
               fpd_pkg::ADR_DSR: prdata_r <= {24'h0, dsr_r};
               fpd_pkg::ADR_DOUT: prdata_r <= {24'h0, digital_output_reg};
               fpd_pkg::ADR_CFGCTL: prdata_r <= {24'h0, config_control_reg};
               // Status shows 00h until ready, then the ready bit
               fpd_pkg::ADR_STAT: prdata_r <= {24'h0, request_for_master ? fpd_pkg::STAT_READY : fpd_pkg::STAT_BUSY};
               fpd_pkg::ADR_DATA: prdata_r <= {24'h0, data_r};
               fpd_pkg::ADR_MODE: prdata_r <= {24'h0, par.mode};
               fpd_pkg::ADR_CFG: prdata_r <= par.cfg;
               // Power register shows the sequencer state in the upper nibble
               fpd_pkg::ADR_PWR: prdata_r <= {24'h0, st_r, pwr_r[3:0]};
               default: prdata_r <= 32'h0;
            endcase
         end
      end
   end

   // Controller reset level, registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_reset <= 1'b1;
      else
         ctl_reset <= (st_nxt == fpd_pkg::ST_INIT);
   end

   // Outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign fdc_clk_en = clk_en_r;
   assign osc_en = osc_en_r;
   assign drive_ctl_out = digital_output_reg;
   assign data_rate = rate_r;
   assign precomp_sel = dsr_r[4:2];
   assign fifo_en = par.cfg[fpd_pkg::CFG_FIFO_BIT];
   assign fifo_threshold_param = par.cfg[fpd_pkg::CFG_THR_MSB:fpd_pkg::CFG_THR_LSB];
   assign precomp_start_track = par.cfg[fpd_pkg::CFG_PRE_MSB:fpd_pkg::CFG_PRE_LSB];
   assign implied_seek_en = par.cfg[fpd_pkg::CFG_ISEEK_BIT];
   assign poll_en = par.cfg[fpd_pkg::CFG_POLL_BIT];
   assign mode_fifo_write_param = par.mode[fpd_pkg::MODE_FIFO_WR_BIT];
   assign mode_fifo_read_param = par.mode[fpd_pkg::MODE_FIFO_RD_BIT];
   assign mode_burst_param = par.mode[fpd_pkg::MODE_BURST_BIT];

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_clk_stop_down: assert property ((st_r == fpd_pkg::ST_DOWN) |-> !clk_en_r)
      else $error("clock running while powered down");
   a_osc_select: assert property ((st_r == fpd_pkg::ST_DOWN) |-> (osc_en_r == !osc_off_r))
      else $error("oscillator gating does not follow select");
   a_rqm_clear_down: assert property ((st_r == fpd_pkg::ST_DOWN) |-> !request_for_master)
      else $error("ready bit set while powered down");
   a_manual_lp_now: assert property ((st_r == fpd_pkg::ST_RUN && dsr_wr && pwdata[6] && !sw_rst)
      |=> (st_r == fpd_pkg::ST_DOWN))
      else $error("manual low power not entered at once");
   a_lp_bit_clear: assert property (($past(st_r) == fpd_pkg::ST_WAKE && st_r != fpd_pkg::ST_WAKE)
      |-> !dsr_r[fpd_pkg::DSR_LP_BIT])
      else $error("low power bit not cleared after wake");
   a_wake_access: assert property ((st_r == fpd_pkg::ST_DOWN && wake_acc) |=> (st_r == fpd_pkg::ST_WAKE))
      else $error("status access did not wake");
   a_swrst_wake: assert property ((st_r == fpd_pkg::ST_DOWN && sw_rst) |=> (st_r == fpd_pkg::ST_WAKE))
      else $error("software reset did not wake");
   a_rqm_low_wake: assert property ((st_r == fpd_pkg::ST_WAKE) |-> !request_for_master ##1 !request_for_master)
      else $error("ready bit set during wake-up");
   a_dsr_selfclr: assert property (dsr_wr |=> !dsr_r[fpd_pkg::DSR_RST_BIT])
      else $error("rate select reset bit stuck");
   a_regs_kept: assert property ((st_r == fpd_pkg::ST_DOWN && !wr) |=> $stable(digital_output_reg))
      else $error("output register changed in power-down");
   a_ready_bound: assert property ((st_r == fpd_pkg::ST_INIT && !hold && $past(st_r) != fpd_pkg::ST_INIT)
      |-> ##[1:630] (st_r != fpd_pkg::ST_INIT || hold))
      else $error("ready not reached in time after reset");
endmodule

// file: bench/fpd_engine_model.sv
// Controller engine stand-in reporting idle and ready to the sequencer
`timescale 1ns/10ps
module fpd_engine_model
(
   // Sequencer controls
   input wire logic fdc_clk_en,
   input wire logic ctl_reset,
   input wire logic want_idle,
   // Engine status
   output logic eng_idle,
   output logic eng_ready
);
   // Ready only with its clock running and out of reset
   assign eng_ready = fdc_clk_en & ~ctl_reset;
   // No clock means no microcode, so idle drops too
   assign eng_idle = want_idle & fdc_clk_en;
endmodule

// file: bench/fpd_power_seq_tb.sv
// Self-checking bench for the power-down and reset sequencer
`timescale 1ns/10ps
module fpd_power_seq_tb;
   localparam int IDLE = 50; // Short idle delay
   localparam int OSC = 20; // Short oscillator settle
   localparam int RDY = fpd_pkg::CYC_RDY + 8; // Ready bound incl. poll slack
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, want_idle = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic pready, pslverr, er, eng_idle, eng_ready, fdc_clk_en, osc_en, ctl_reset;
   logic fifo_en, implied_seek_en, poll_en, mode_fifo_write_param, mode_fifo_read_param, mode_burst_param;
   logic [7:0] drive_ctl_out, precomp_start_track;
   logic [3:0] fifo_threshold_param;
   logic [2:0] precomp_sel;
   logic [1:0] data_rate;
   int errors = 0, tests_run = 0, cnt = 0;
   // 250 MHz clock and free cycle count
   always #2 pclk = ~pclk;
   always @(posedge pclk) cnt <= cnt + 1;
   fpd_power_seq #(.IDLE_CYC(IDLE), .OSC_CYC(OSC)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .eng_idle, .eng_ready, .fdc_clk_en, .osc_en, .ctl_reset, .drive_ctl_out,
      .data_rate, .precomp_sel, .fifo_en, .fifo_threshold_param, .precomp_start_track, .implied_seek_en,
      .poll_en, .mode_fifo_write_param, .mode_fifo_read_param, .mode_burst_param);
   fpd_engine_model eng (.fdc_clk_en, .ctl_reset, .want_idle, .eng_idle, .eng_ready);
   // Report and stop
   task automatic conclude();
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // One comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Wait as long as the slave takes; only the watchdog ends a hang
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(0, a, 0);
      chk(what, exp, rd);
   endtask
   // Wait n edges, then let outputs settle
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // Poll status until ready; elapsed cycles must sit inside lo..hi
   task automatic wait_rdy(input int lo, input int hi);
      int t0;
      t0 = cnt;
      do
         apb(0, fpd_pkg::ADR_STAT, 0);
      while (rd !== 32'h80 && cnt - t0 < hi + 10);
      chk("msr ready in window", 1, {31'h0, rd === 32'h80 && cnt - t0 >= lo && cnt - t0 <= hi});
   endtask
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      #1;
      chk("drive_ctl_out", 8'h04, drive_ctl_out);
      chk("poll_en", 1, poll_en);
      chk("fifo", 0, {fifo_en, fifo_threshold_param, implied_seek_en});
      chk("clk osc reset", 3'b111, {fdc_clk_en, osc_en, ctl_reset});
      rdchk(fpd_pkg::ADR_STAT, 0, "status after reset");
      wait_rdy(0, RDY);
      apb(1, 8'h20, 32'h1);
      chk("slverr", 1, er);
      // Lock the parameters, then hold a software reset through the output register
      apb(1, fpd_pkg::ADR_CFG, 32'h8000_051f);
      apb(1, fpd_pkg::ADR_MODE, 32'h1c);
      apb(1, fpd_pkg::ADR_DOUT, 0);
      cyc(1);
      chk("ctl_reset", 1, ctl_reset);
      rdchk(fpd_pkg::ADR_DOUT, 0, "output reset bit held");
      rdchk(fpd_pkg::ADR_STAT, 0, "status in reset");
      apb(1, fpd_pkg::ADR_CFGCTL, 3);
      cyc(1);
      chk("rate in reset", 3, data_rate);
      chk("locked cfg", 'h1f05, {fifo_threshold_param, fifo_en, precomp_start_track});
      chk("locked mode", 7, {mode_fifo_write_param, mode_fifo_read_param, mode_burst_param});
      apb(1, fpd_pkg::ADR_DOUT, 32'h04);
      wait_rdy(0, RDY);
      // Self-clearing reset through rate select, precomp field set alongside
      apb(1, fpd_pkg::ADR_DSR, 32'h8c);
      rdchk(fpd_pkg::ADR_DSR, 32'h0c, "rate select reset bit");
      chk("precomp_sel", 3, precomp_sel);
      wait_rdy(0, RDY);
      chk("locked cfg 2", 'h1f05, {fifo_threshold_param, fifo_en, precomp_start_track});
      // Manual low power, oscillator kept
      apb(1, fpd_pkg::ADR_DSR, 32'h40);
      cyc(1);
      chk("clk off osc on", 1, {fdc_clk_en, osc_en});
      apb(1, fpd_pkg::ADR_CFGCTL, 2);
      cyc(1);
      chk("rate while down", 2, data_rate);
      rdchk(fpd_pkg::ADR_DOUT, 32'h04, "output register while down");
      rdchk(fpd_pkg::ADR_STAT, 0, "status while down");
      wait_rdy(0, 10);
      rdchk(fpd_pkg::ADR_DSR, 0, "low power bit");
      // Oscillator stopped, woken by a data access; ready only after the oscillator settle time
      apb(1, fpd_pkg::ADR_PWR, 1);
      apb(1, fpd_pkg::ADR_DSR, 32'h40);
      cyc(1);
      chk("osc off", 0, {fdc_clk_en, osc_en});
      apb(0, fpd_pkg::ADR_DATA, 0);
      wait_rdy(OSC, OSC + 10);
      chk("fifo kept", 1, fifo_en);
      // Mode manual bit, then output register reset to wake
      apb(1, fpd_pkg::ADR_PWR, 0);
      apb(1, fpd_pkg::ADR_MODE, 32'h1d);
      cyc(1);
      chk("mode low power", 0, fdc_clk_en);
      apb(1, fpd_pkg::ADR_DOUT, 0);
      apb(1, fpd_pkg::ADR_DOUT, 32'h04);
      wait_rdy(0, RDY);
      // Automatic low power after idle, twice without re-arming
      apb(1, fpd_pkg::ADR_MODE, 32'h1e);
      want_idle <= 1;
      cyc(IDLE - 5);
      chk("not yet down", 1, fdc_clk_en);
      cyc(10);
      chk("auto down", 0, fdc_clk_en);
      wait_rdy(0, 10);
      cyc(IDLE + 10);
      chk("auto down again", 0, fdc_clk_en);
      @(posedge pclk);
      want_idle <= 0;
      wait_rdy(0, 10);
      // Master reset mid-run drops even the locked parameters
      @(posedge pclk);
      presetn <= 0;
      cyc(3);
      @(posedge pclk);
      presetn <= 1;
      cyc(1);
      chk("fifo after master reset", 0, {fifo_en, fifo_threshold_param, mode_fifo_write_param});
      chk("drive out after master reset", 8'h04, drive_ctl_out);
      rdchk(fpd_pkg::ADR_STAT, 0, "status after master reset");
      wait_rdy(0, RDY);
      conclude();
   end
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge pclk);
      errors++;
      conclude();
   end
endmodule
